/* rtl/sync_comm_pkg.sv */
// Shared constants, field layouts, states and carrier structs of the init and status block.
// Assumes a single 40 MHz clock domain and a host that sees 16-bit device registers.
package sync_comm_pkg;

  localparam int DATA_W      = 16;
  localparam int HIGH_ADDR_W = 6;
  localparam int BUS_ADDR_W  = DATA_W + HIGH_ADDR_W;
  localparam int CHAN_W      = 2;
  localparam int NUM_CHAN    = 4;
  localparam int SYNC_W      = 3;
  localparam int CNT_W       = 16;

  // Register indices on the host register port.
  localparam logic [1:0] REG_LOW  = 2'h0;
  localparam logic [1:0] REG_HIGH = 2'h1;
  localparam logic [1:0] REG_FLAG = 2'h2;

  // Flag register bit positions.
  localparam int FLAG_RESET_BIT = 9;
  localparam int FLAG_RUN_BIT   = 10;
  localparam int FLAG_ABORT_BIT = 15;

  // Self-test result codes in the low register.
  localparam logic [15:0] CODE_PASS = 16'hAAAA;
  localparam logic [15:0] CODE_FAIL = 16'h5555;
  localparam logic [15:0] CODE_SKIP = 16'h55AA;

  // Command codes and the only legal diagnostic parameter.
  localparam logic [7:0]  CMD_STATUS_CHANGE = 8'h50;
  localparam logic [7:0]  CMD_DIAG          = 8'h7F;
  localparam logic [31:0] DIAG_P1           = 32'h0000_0001;

  // Reason codes of an unsolicited status block.
  localparam logic [7:0] REASON_MODEM = 8'h01;
  localparam logic [7:0] REASON_CABLE = 8'h02;

  // Self-test numbering.
  localparam logic [7:0] FIRST_TEST          = 8'h01;
  localparam logic [7:0] NUM_TESTS           = 8'h0D;
  localparam logic [7:0] FIRST_REPORTED_TEST = 8'h06;

  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;

  typedef struct packed {
    logic [15:0] unused;
    logic [7:0]  info;
    logic [7:0]  reason;
  } status_p1_s;

  typedef struct packed {
    logic [7:0] test_num;
    logic [7:0] err_num;
  } result_high_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [1:0]        sel;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic              valid;
    logic [7:0]        code;
    logic [CHAN_W-1:0] chan;
    logic [31:0]       first_param_longword;
  } cmd_s;

  typedef struct packed {
    logic              modem_valid;
    logic              cable_valid;
    logic [CHAN_W-1:0] chan;
    logic [7:0]        modem_status;
    logic [7:0]        cable_code;
  } evt_s;

  typedef struct packed {
    logic              valid;
    logic [CHAN_W-1:0] chan;
    status_p1_s        first_param_longword;
    logic [31:0]       second_param_longword;
  } resp_s;

  typedef enum logic [2:0] {
    S_TEST  = 3'h0,
    S_IDLE  = 3'h1,
    S_FETCH = 3'h3,
    S_RUN   = 3'h2
  } init_state_e;

  typedef enum logic {
    T_IDLE = 1'h0,
    T_RUN  = 1'h1
  } test_state_e;

endpackage

/* rtl/self_test_seq.sv */
// Self-test sequencer: steps through the numbered tests and reports pass or the first failure.
// Assumes the datapath raises test_fail with fail_code while a failing test is running.
`timescale 1ns/1ps
module self_test_seq
  import sync_comm_pkg::*;
#(
  parameter int TEST_CYCLES = 16
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       test_fail,
  input  wire logic [7:0] fail_code,
  output logic            done,
  output logic            passed,
  output logic [7:0]      test_num,
  output logic [7:0]      err_num
);
  import sync_comm_pkg::*;

  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(TEST_CYCLES - 1);

  typedef struct packed {
    test_state_e      st;
    logic [7:0]       test;
    logic [CNT_W-1:0] cnt;
    logic             done;
    logic             passed;
    logic [7:0]       test_num;
    logic [7:0]       err_num;
  } seq_s;

  seq_s q_reg;
  seq_s q_next;

  always_comb begin
    q_next      = q_reg;
    q_next.done = 1'b0;
    if (start) begin
      q_next.st       = T_RUN;
      q_next.test     = FIRST_TEST;
      q_next.cnt      = '0;
      q_next.passed   = 1'b0;
      q_next.test_num = ZERO_BYTE;
      q_next.err_num  = ZERO_BYTE;
    end else if (q_reg.st == T_RUN) begin
      if (test_fail) begin
        q_next.err_num = fail_code;
        q_next.done    = 1'b1;
        q_next.st      = T_IDLE;
      end else if (q_reg.cnt == LAST_CNT) begin
        if (q_reg.test == NUM_TESTS) begin
          q_next.passed = 1'b1;
          q_next.done   = 1'b1;
          q_next.st     = T_IDLE;
        end else begin
          q_next.test = q_reg.test + 8'h01;
          q_next.cnt  = '0;
          if (q_next.test >= FIRST_REPORTED_TEST) begin
            q_next.test_num = q_next.test;
          end
        end
      end else begin
        q_next.cnt = q_reg.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign done     = q_reg.done;
  assign passed   = q_reg.passed;
  assign test_num = q_reg.test_num;
  assign err_num  = q_reg.err_num;

endmodule // self_test_seq

/* rtl/sync_comm_init.sv */
// Initialization handshake, self-test reporting, status-change and diagnostic commands.
// Assumes a host on the register port, a memory port that acknowledges reads, and
// command and event strobes produced by logic on the same clock.
`timescale 1ns/1ps
module sync_comm_init
  import sync_comm_pkg::*;
#(
  parameter int TEST_CYCLES = 16
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  bus_init,
  input  wire sync_comm_pkg::reg_req_s reg_req,
  output logic [DATA_W-1:0]          reg_rdata,
  input  wire sync_comm_pkg::cmd_s   cmd,
  input  wire sync_comm_pkg::evt_s   evt,
  output sync_comm_pkg::resp_s       resp,
  output logic                       mem_req,
  output logic [BUS_ADDR_W-1:0]      mem_addr,
  input  wire logic                  mem_ack,
  input  wire logic                  test_fail,
  input  wire logic [7:0]            fail_code,
  output logic                       lists_running,
  output logic                       diag_mode
);
  import sync_comm_pkg::*;

  typedef struct packed {
    init_state_e             st;
    logic [SYNC_W-1:0]       sync;
    logic                    bus_init_lvl;
    logic [DATA_W-1:0]       addr_low;
    result_high_s            addr_high;
    logic                    reset_busy;
    logic                    run;
    logic                    running;
    logic                    diag;
    logic                    start;
    logic [NUM_CHAN-1:0]     pend;
    logic [DATA_W-1:0]       rdata;
    logic                    mem_req;
    logic [BUS_ADDR_W-1:0]   mem_addr;
    resp_s                   resp;
  } state_s;

  // One register holds the whole state; q_next is its value for the next edge.
  state_s q_reg;
  state_s q_next;

  // Self-test progress, registered inside the sequencer.
  logic       st_done;
  logic       st_passed;
  logic [7:0] st_test_num;
  logic [7:0] st_err_num;

  self_test_seq #(
    .TEST_CYCLES (TEST_CYCLES)
  ) u_self_test (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .start     (q_reg.start),
    .test_fail (test_fail),
    .fail_code (fail_code),
    .done      (st_done),
    .passed    (st_passed),
    .test_num  (st_test_num),
    .err_num   (st_err_num)
  );

  // Decoded requests of this cycle, shared by the state machine below.
  logic              bus_init_rise;
  logic              flag_wr;
  logic              soft_reset;
  logic              abort_req;
  logic              addr_wr_ok;
  logic              low_wr;
  logic              high_wr;
  logic              run_req;
  logic              modem_hit;
  logic              cable_hit;
  logic              status_cmd;
  logic              diag_cmd;
  logic [DATA_W-1:0] flag_word;

  always_comb begin
    q_next       = q_reg;
    q_next.start = 1'b0;
    // Answers are one-cycle pulses, so every cycle starts from an empty block.
    q_next.resp  = '0;

    // The pin is only trusted once the second and third stages agree.
    q_next.sync = {q_reg.sync[1], q_reg.sync[0], bus_init};
    if (q_reg.sync[1] == q_reg.sync[2]) begin
      q_next.bus_init_lvl = q_reg.sync[2];
    end
    // Only the rising level counts, so a bus reset held for long restarts init once.
    bus_init_rise = q_next.bus_init_lvl & ~q_reg.bus_init_lvl;

    flag_wr = reg_req.wr && (reg_req.sel == REG_FLAG);
    // Software reset ignored in diagnostic mode.
    soft_reset = flag_wr && reg_req.wdata[FLAG_RESET_BIT] &&
                 !q_reg.diag && !q_reg.reset_busy;
    // Abort only counts in the reset write.
    abort_req = soft_reset && reg_req.wdata[FLAG_ABORT_BIT];
    addr_wr_ok = reg_req.wr && (q_reg.st == S_IDLE) && !q_reg.reset_busy && !q_reg.run;
    low_wr  = addr_wr_ok && (reg_req.sel == REG_LOW);
    high_wr = addr_wr_ok && (reg_req.sel == REG_HIGH);
    // Run request decoded.
    // A write that sets both reset and run is taken as a reset; the run bit is dropped.
    run_req = flag_wr && reg_req.wdata[FLAG_RUN_BIT] &&
              !q_reg.reset_busy && !soft_reset;

    // Answer only from held block.
    // Events on a channel with no held block are dropped, not queued.
    modem_hit  = evt.modem_valid && q_reg.pend[evt.chan];
    cable_hit  = evt.cable_valid && q_reg.pend[evt.chan];
    status_cmd = cmd.valid && (cmd.code == CMD_STATUS_CHANGE);
    diag_cmd   = cmd.valid && (cmd.code == CMD_DIAG) &&
                 (cmd.first_param_longword == DIAG_P1);

    flag_word                 = ZERO_WORD;
    flag_word[FLAG_RESET_BIT] = q_reg.reset_busy;
    flag_word[FLAG_RUN_BIT]   = q_reg.run;

    if (reg_req.rd) begin
      case (reg_req.sel)
        REG_LOW: begin
          q_next.rdata = q_reg.addr_low;
        end
        REG_HIGH: begin
          q_next.rdata = q_reg.addr_high;
        end
        REG_FLAG: begin
          q_next.rdata = flag_word;
        end
        default: begin
          q_next.rdata = ZERO_WORD;
        end
      endcase
    end

    case (q_reg.st)
      S_TEST: begin
        q_next.addr_high.test_num = st_test_num;
        q_next.addr_high.err_num  = st_err_num;
        if (st_done) begin
          q_next.addr_low = st_passed ? CODE_PASS : CODE_FAIL;
          if (q_reg.diag) begin
            // Continuous self-test loop.
            // The loop never ends by itself; each pass refreshes the low register.
            q_next.start = 1'b1;
          end else begin
            q_next.reset_busy = 1'b0;
            q_next.st         = S_IDLE;
          end
        end
      end
      S_IDLE: begin
        if (low_wr) begin
          q_next.addr_low = reg_req.wdata;
        end
        if (high_wr) begin
          q_next.addr_high = reg_req.wdata;
        end
        // Both halves are taken as they stand now, so the run write may follow at once.
        if (run_req) begin
          q_next.mem_addr = {q_next.addr_high[HIGH_ADDR_W-1:0], q_next.addr_low};
          q_next.mem_req  = 1'b1;
          q_next.run      = 1'b1;
          q_next.st       = S_FETCH;
        end
      end
      S_FETCH: begin
        // No timeout: a memory that never answers holds the fetch until a reset.
        if (mem_ack) begin
          q_next.mem_req = 1'b0;
          q_next.running = 1'b1;
          q_next.st      = S_RUN;
        end
      end
      S_RUN: begin
        if (modem_hit) begin
          q_next.pend[evt.chan] = 1'b0;
          q_next.resp.valid     = 1'b1;
          q_next.resp.chan      = evt.chan;
          q_next.resp.first_param_longword.reason = REASON_MODEM;
          q_next.resp.first_param_longword.info   = evt.modem_status;
        end else if (cable_hit) begin
          q_next.pend[evt.chan] = 1'b0;
          q_next.resp.valid     = 1'b1;
          q_next.resp.chan      = evt.chan;
          q_next.resp.first_param_longword.reason = REASON_CABLE;
          q_next.resp.first_param_longword.info   = evt.cable_code;
        end
        q_next.resp.first_param_longword.unused = ZERO_WORD;
        q_next.resp.second_param_longword       = '0;
        // A new block in the same cycle as an answer wins, so it is never lost.
        if (status_cmd) begin
          q_next.pend[cmd.chan] = 1'b1;
        end
        if (diag_cmd) begin
          q_next.diag       = 1'b1;
          q_next.run        = 1'b0;
          q_next.running    = 1'b0;
          q_next.reset_busy = 1'b1;
          q_next.pend       = '0;
          q_next.start      = 1'b1;
          q_next.st         = S_TEST;
        end
      end
      default: begin
        q_next.st = S_TEST;
      end
    endcase

    // Bus reset or reset bit starts init.
    if (bus_init_rise || soft_reset) begin
      q_next.diag       = 1'b0;
      q_next.run        = 1'b0;
      q_next.running    = 1'b0;
      q_next.mem_req    = 1'b0;
      q_next.pend       = '0;
      q_next.resp       = '0;
      q_next.reset_busy = 1'b1;
      q_next.start      = 1'b1;
      q_next.st         = S_TEST;
      if (abort_req && !bus_init_rise) begin
        q_next.start      = 1'b0;
        q_next.reset_busy = 1'b0;
        q_next.addr_low   = CODE_SKIP;
        q_next.addr_high  = ZERO_WORD;
        q_next.st         = S_IDLE;
      end
    end
  end

  // Power-on behaves like a bus reset: the self-test starts right after release.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg            <= '0;
      q_reg.st         <= S_TEST;
      q_reg.reset_busy <= 1'b1;
      q_reg.start      <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  // Every output is a register field, so nothing combinational reaches the pins.
  assign reg_rdata     = q_reg.rdata;
  assign resp          = q_reg.resp;
  assign mem_req       = q_reg.mem_req;
  assign mem_addr      = q_reg.mem_addr;
  assign lists_running = q_reg.running;
  assign diag_mode     = q_reg.diag;

endmodule // sync_comm_init

/* test/sync_comm_chk.sv */
// Concurrent checks on the ports of sync_comm_init.
// Assumes host strobes, commands and events arrive as one-cycle pulses on mclk.
`timescale 1ns/1ps
module sync_comm_chk
  import sync_comm_pkg::*;
#(
  parameter int TEST_CYCLES = 16
) (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  bus_init,
  input wire sync_comm_pkg::reg_req_s reg_req,
  input wire logic [DATA_W-1:0]     reg_rdata,
  input wire sync_comm_pkg::cmd_s   cmd,
  input wire sync_comm_pkg::evt_s   evt,
  input wire sync_comm_pkg::resp_s  resp,
  input wire logic                  mem_req,
  input wire logic [BUS_ADDR_W-1:0] mem_addr,
  input wire logic                  mem_ack,
  input wire logic                  test_fail,
  input wire logic [7:0]            fail_code,
  input wire logic                  lists_running,
  input wire logic                  diag_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  resp_pulse_a: assert property (resp.valid |=> !resp.valid)
    else $error("status answer longer than one cycle");
  reason_legal_a: assert property (resp.valid |->
    (resp.first_param_longword.reason == REASON_MODEM ||
     resp.first_param_longword.reason == REASON_CABLE) &&
    resp.first_param_longword.unused == ZERO_WORD && resp.second_param_longword == 32'h0000_0000)
    else $error("bad reason or nonzero unused bits");
  modem_info_a: assert property (resp.valid && resp.first_param_longword.reason == REASON_MODEM |->
    $past(evt.modem_valid) && resp.first_param_longword.info == $past(evt.modem_status) &&
    resp.chan == $past(evt.chan))
    else $error("modem answer does not match event");
  cable_info_a: assert property (resp.valid && resp.first_param_longword.reason == REASON_CABLE |->
    $past(evt.cable_valid) && !$past(evt.modem_valid) &&
    resp.first_param_longword.info == $past(evt.cable_code))
    else $error("cable answer does not match event");
  diag_enter_a: assert property (lists_running && cmd.valid && cmd.code == CMD_DIAG &&
    cmd.first_param_longword == DIAG_P1 |=> diag_mode && !lists_running)
    else $error("diagnostic command not taken");
  diag_hold_a: assert property ((!bus_init)[*6] ##0 diag_mode |=> diag_mode)
    else $error("diagnostic mode left without bus reset");
  fetch_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch request dropped or address moved");
  run_start_a: assert property (mem_req && mem_ack |=> !mem_req && lists_running)
    else $error("lists not running after fetch");
  run_cause_a: assert property ($rose(lists_running) |-> $past(mem_ack))
    else $error("lists running without fetch");
  flag_read_a: assert property (reg_req.rd && reg_req.sel == REG_FLAG |=>
    (reg_rdata & 16'hF9FF) == ZERO_WORD)
    else $error("flag read shows undefined bits");
endmodule // sync_comm_chk

bind sync_comm_init sync_comm_chk #(.TEST_CYCLES(TEST_CYCLES)) chk_i (
  .mclk          (mclk),
  .rst_n         (rst_n),
  .bus_init      (bus_init),
  .reg_req       (reg_req),
  .reg_rdata     (reg_rdata),
  .cmd           (cmd),
  .evt           (evt),
  .resp          (resp),
  .mem_req       (mem_req),
  .mem_addr      (mem_addr),
  .mem_ack       (mem_ack),
  .test_fail     (test_fail),
  .fail_code     (fail_code),
  .lists_running (lists_running),
  .diag_mode     (diag_mode)
);

/* test/host_mem_model.sv */
// Host memory that answers the init-block fetch after a chosen number of cycles.
// Assumes one outstanding fetch; the last fetched address is shown for checking.
`timescale 1ns/1ps
module host_mem_model
  import sync_comm_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            delay,
  input  wire logic                  mem_req,
  input  wire logic [BUS_ADDR_W-1:0] mem_addr,
  output logic                       mem_ack,
  output logic [BUS_ADDR_W-1:0]      seen_addr
);
  logic [3:0] cnt;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 4'h0;
      mem_ack   <= 1'b0;
      seen_addr <= '0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) begin
        if (cnt == delay) begin
          mem_ack   <= 1'b1;
          seen_addr <= mem_addr;
          cnt       <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // host_mem_model

/* test/tb_top.sv */
// Self-checking bench for sync_comm_init with a host memory model.
// Assumes a 40 MHz clock; inputs change 2 ns after each rising edge.
`timescale 1ns/1ps
module tb_top;
  import sync_comm_pkg::*;
  localparam int TC = 4;
  logic                  mclk      = 1'b0;
  logic                  rst_n     = 1'b0;
  logic                  bus_init  = 1'b0;
  reg_req_s              reg_req   = '0;
  cmd_s                  cmd       = '0;
  evt_s                  evt       = '0;
  logic                  test_fail = 1'b0;
  logic [7:0]            fail_code = 8'h00;
  logic [DATA_W-1:0]     reg_rdata;
  resp_s                 resp;
  logic                  mem_req;
  logic                  mem_ack;
  logic                  lists_running;
  logic                  diag_mode;
  logic [BUS_ADDR_W-1:0] mem_addr;
  logic [BUS_ADDR_W-1:0] seen_addr;
  int                    n_fail    = 0;
  int                    checks    = 0;

  always #12.5 mclk = ~mclk;

  sync_comm_init #(.TEST_CYCLES(TC)) dut (.mclk(mclk), .rst_n(rst_n), .bus_init(bus_init),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .cmd(cmd), .evt(evt), .resp(resp),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .test_fail(test_fail),
    .fail_code(fail_code), .lists_running(lists_running), .diag_mode(diag_mode));

  // A slow memory answer keeps the fetch request standing for several cycles.
  host_mem_model mem (.mclk(mclk), .rst_n(rst_n), .delay(4'h3), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .seen_addr(seen_addr));

  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic step;
    @(posedge mclk);
    #2;
  endtask

  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    step();
    reg_req = '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
    step();
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [1:0] s, output logic [15:0] d);
    step();
    reg_req = '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 16'h0000};
    step();
    reg_req.rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic send(input logic [7:0] c, input logic [1:0] ch, input logic [31:0] p);
    step();
    cmd = '{valid: 1'b1, code: c, chan: ch, first_param_longword: p};
    step();
    cmd.valid = 1'b0;
  endtask

  task automatic ev(input logic md, input logic [1:0] ch, input logic [7:0] v,
                    input logic hit, input logic [31:0] p1);
    logic got;
    got = 1'b0;
    step();
    evt = '{modem_valid: md, cable_valid: !md, chan: ch, modem_status: v, cable_code: v};
    step();
    evt.modem_valid = 1'b0;
    evt.cable_valid = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (resp.valid === 1'b1 && !got) begin
        got = 1'b1;
        chk("status block", p1, resp.first_param_longword);
      end
      step();
    end
    chk("status answer", {31'h0, hit}, {31'h0, got});
  endtask

  // The host must not touch the address registers until the busy flag drops.
  task automatic init_result(input logic [15:0] low, input logic [7:0] err);
    logic [15:0] v;
    for (int i = 0; i < 300; i++) begin
      rd(REG_FLAG, v);
      if (v[FLAG_RESET_BIT] === 1'b0)
        break;
    end
    chk("reset flag", 32'h0, {31'h0, v[FLAG_RESET_BIT]});
    rd(REG_LOW, v);
    chk("low result", {16'h0, low}, {16'h0, v});
    chk("result code legal", 32'h1, {31'h0, (v == CODE_PASS || v == CODE_FAIL || v == CODE_SKIP)});
    rd(REG_HIGH, v);
    chk("error number", {24'h0, err}, {24'h0, v[7:0]});
    if (low == CODE_PASS)
      chk("test number", {24'h0, NUM_TESTS}, {24'h0, v[15:8]});
  endtask

  task automatic t_selftest;
    logic [15:0] v;
    init_result(CODE_PASS, ZERO_BYTE);
    test_fail = 1'b1;
    fail_code = 8'h5A;
    wr(REG_FLAG, 16'h0200);
    init_result(CODE_FAIL, 8'h5A);
    test_fail = 1'b0;
    wr(REG_FLAG, 16'h8200);
    rd(REG_FLAG, v);
    chk("skip flag", 32'h0, {31'h0, v[FLAG_RESET_BIT]});
    rd(REG_LOW, v);
    chk("skip code", {16'h0, CODE_SKIP}, {16'h0, v});
  endtask

  task automatic t_run;
    logic [15:0] v;
    wr(REG_LOW, 16'h1234);
    wr(REG_HIGH, 16'hFFE5);
    wr(REG_FLAG, 16'h0400);
    for (int i = 0; i < 20 && lists_running !== 1'b1; i++)
      step();
    chk("lists running", 32'h1, {31'h0, lists_running});
    chk("fetch address", {10'h0, 22'h25_1234}, {10'h0, seen_addr});
    rd(REG_LOW, v);
    chk("low after run", 32'h0000_1234, {16'h0, v});
  endtask

  task automatic t_status;
    send(CMD_STATUS_CHANGE, 2'h1, 32'h0000_0000);
    ev(1'b1, 2'h1, 8'hA5, 1'b1, 32'h0000_A501);
    ev(1'b0, 2'h1, 8'h3C, 1'b0, 32'h0000_0000);
    send(CMD_STATUS_CHANGE, 2'h1, 32'h0000_0000);
    ev(1'b0, 2'h1, 8'h66, 1'b1, 32'h0000_6602);
    send(CMD_STATUS_CHANGE, 2'h2, 32'h0000_0000);
    ev(1'b0, 2'h2, 8'h3C, 1'b1, 32'h0000_3C02);
    ev(1'b1, 2'h3, 8'h11, 1'b0, 32'h0000_0000);
  endtask

  task automatic t_diag;
    send(CMD_DIAG, 2'h0, 32'h0000_0002);
    chk("reserved diag", 32'h0, {31'h0, diag_mode});
    send(CMD_DIAG, 2'h0, DIAG_P1);
    chk("diag mode", 32'h1, {31'h0, diag_mode});
    wr(REG_FLAG, 16'h0200);
    repeat (4) step();
    chk("diag after soft reset", 32'h1, {31'h0, diag_mode});
    bus_init = 1'b1;
    repeat (8) step();
    bus_init = 1'b0;
    chk("diag after bus reset", 32'h0, {31'h0, diag_mode});
    init_result(CODE_PASS, ZERO_BYTE);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    t_selftest();
    t_run();
    t_status();
    t_diag();
    results();
  end

  initial begin
    #2_000_000;
    n_fail++;
    results();
  end
endmodule // tb_top
